// >>> qdrc_top.sv
// Quad 12-bit converter register control: APB slave, four channels.
// Assumes timer event, reference enable and warm reset come from logic
// on sys_clk, so they are used without synchronisers.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "qdrc_defs.svh"

// Functional notes
// - Four channels, each with identical control and code registers.
// - Code register holds 12-bit code in bits 27:16; rest reserved.
// - Control bit 6 set bypasses the output buffer, clear enables it.
// - Control bit 5 picks update on timer one event or core clock.
// - Control bit 4 low forces the code register to zero.
// - Control bits 3 and 2 always read zero.
// - Range code: 00 off and tristate, 01 reserved, 10 vref, 11 supply.
// - Retention set: warm reset leaves converter outputs unchanged.
// - Reference enable with code 01: external reference to both sides.
// - Reference enable with code 10: internal reference for the channel; sampling converter internal unless a channel is on code 01.
// - Code 11: channel on supply; sampling converter follows enable.
// - Code 00: channel off; sampling converter follows enable.
// - Retention clear: warm reset returns channel pins and registers to default.
module qdrc_top (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        general_timer_one_event,
  input  wire logic        reference_enable,
  input  wire logic        warm_reset,
  input  wire logic        retention_keep,
  output logic [47:0]      channel_code_out,
  output logic [3:0]       channel_powered,
  output logic [3:0]       buffer_bypass,
  output logic [3:0]       dac_ref_supply,
  output logic [3:0]       dac_ref_internal,
  output logic [3:0]       dac_ref_external,
  output logic             adc_ref_external
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [7:0]  ctrl_reg   [4];
  logic [11:0] code_reg   [4];
  logic [11:0] dac_in_reg [4];
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        adc_ext_reg;
  logic [3:0]  pwr_reg;
  logic [3:0]  byp_reg;
  logic [3:0]  sup_reg;
  logic [3:0]  int_reg;
  logic [3:0]  ext_reg;
  logic        access_start;
  logic        commit;
  logic        warm_clear;
  logic [1:0]  sel_idx;
  logic        any_ext_req;

  // --------------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------------
  // Window of eight aligned words starting at the first control word
  function automatic logic addr_ok(input logic [31:0] a);
    logic [31:0] base;
    base    = `QDRC_CONV0_CONTROL;
    addr_ok = (a[31:5] == base[31:5]) && (a[1:0] == 2'b00);
  endfunction : addr_ok

  // Read value of one mapped word; reserved bits come back as zero
  function automatic logic [31:0] rd_value(input logic [31:0] a);
    logic [1:0] i;
    i = a[4:3];
    if (a[2])
      rd_value = {4'h0, code_reg[i], 16'h0000};
    else
      rd_value = {24'h000000, ctrl_reg[i]};
  endfunction : rd_value

  // One wait state: pready rises in the second access cycle
  assign access_start = psel & penable & ~pready_reg;
  assign commit       = psel & penable & pready_reg & addr_ok(paddr);
  assign sel_idx      = paddr[4:3];
  // A warm reset only wipes the channels when retention is off
  assign warm_clear   = warm_reset & ~retention_keep;
  // Any channel on range code 01 pulls the sampling converter external
  assign any_ext_req  = (ctrl_reg[0][1:0] == 2'b01) ||
                        (ctrl_reg[1][1:0] == 2'b01) ||
                        (ctrl_reg[2][1:0] == 2'b01) ||
                        (ctrl_reg[3][1:0] == 2'b01);

  // --------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------
  // Registered ready keeps every bus output straight off a flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= access_start;
      pslverr_reg <= access_start & ~addr_ok(paddr);
      if (access_start && !pwrite && addr_ok(paddr))
        prdata_reg <= rd_value(paddr);
      else
        prdata_reg <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------------
  // Channel registers
  // --------------------------------------------------------------------
  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    qdrc_pkg::qdrc_range_t rng;
    assign rng = qdrc_pkg::qdrc_range_t'(
                 ctrl_reg[ch][`QDRC_RANGE_MSB:`QDRC_RANGE_LSB]);

    // Control word; reserved bits never stored
    always_ff @(posedge sys_clk) begin
      if (sys_rst || warm_clear)
        ctrl_reg[ch] <= `QDRC_CTRL_RESET;
      else if (commit && pwrite && !paddr[2] && sel_idx == ch)
        ctrl_reg[ch] <= pwdata[7:0] & `QDRC_CTRL_WMASK;
    end

    // Code word; held at zero while the clear bit is low
    always_ff @(posedge sys_clk) begin
      if (sys_rst || warm_clear)
        code_reg[ch] <= `QDRC_CODE_RESET;
      else if (!ctrl_reg[ch][`QDRC_CLEAR_N_BIT])
        code_reg[ch] <= `QDRC_CODE_RESET;
      else if (commit && pwrite && paddr[2] && sel_idx == ch)
        code_reg[ch] <= pwdata[`QDRC_CODE_MSB:`QDRC_CODE_LSB];
    end

    // Converter input: follows the code, or waits for the timer event
    always_ff @(posedge sys_clk) begin
      if (sys_rst || warm_clear)
        dac_in_reg[ch] <= `QDRC_CODE_RESET;
      else if (!ctrl_reg[ch][`QDRC_UPDSEL_BIT])
        dac_in_reg[ch] <= code_reg[ch];
      else if (general_timer_one_event)
        dac_in_reg[ch] <= code_reg[ch];
    end

    // Power, buffer and reference steering; reserved combos power down
    always_ff @(posedge sys_clk) begin
      if (sys_rst || warm_clear) begin
        pwr_reg[ch] <= 1'b0;
        byp_reg[ch] <= 1'b0;
        sup_reg[ch] <= 1'b0;
        int_reg[ch] <= 1'b0;
        ext_reg[ch] <= 1'b0;
      end else begin
        byp_reg[ch] <= ctrl_reg[ch][`QDRC_BYPASS_BIT];
        sup_reg[ch] <= (rng == qdrc_pkg::QDRC_RNG_SUPPLY);
        int_reg[ch] <= reference_enable &&
                       (rng == qdrc_pkg::QDRC_RNG_VREF);
        ext_reg[ch] <= reference_enable &&
                       (rng == qdrc_pkg::QDRC_RNG_RSV);
        pwr_reg[ch] <= (rng == qdrc_pkg::QDRC_RNG_SUPPLY) ||
                       (reference_enable &&
                        rng != qdrc_pkg::QDRC_RNG_OFF);
      end
    end

    assign channel_code_out[ch*12 +: 12] = dac_in_reg[ch];
  end

  // Sampling converter goes external when enable is low, or when any
  // channel asks for the external reference with enable high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      adc_ext_reg <= 1'b0;
    end else begin
      adc_ext_reg <= !reference_enable || any_ext_req;
    end
  end

  assign pready           = pready_reg;
  assign prdata           = prdata_reg;
  assign pslverr          = pslverr_reg;
  assign channel_powered  = pwr_reg;
  assign buffer_bypass    = byp_reg;
  assign dac_ref_supply   = sup_reg;
  assign dac_ref_internal = int_reg;
  assign dac_ref_external = ext_reg;
  assign adc_ref_external = adc_ext_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence sq_setup;
    psel && !penable;
  endsequence
  sequence sq_first_access;
    psel && penable && !pready_reg;
  endsequence

  AST_APB_ONE_WAIT: assert property (
    sq_setup ##1 sq_first_access |=> pready_reg ##1 !pready_reg)
    else $error("ready not exactly one wait state after setup");

  // Reset still sampled at the release edge keeps the flop at zero
  AST_ADC_EXT_OFF: assert property (
    !sys_rst && !reference_enable |=> adc_ref_external)
    else $error("sampling converter not on external reference");

  AST_ADC_INTERNAL: assert property (
    reference_enable && !any_ext_req |=> !adc_ref_external)
    else $error("sampling converter not on internal reference");

  AST_REFUSED_ANSWER: assert property (
    access_start && !addr_ok(paddr) |=> pready_reg && pslverr_reg &&
                                         prdata_reg == 32'h00000000)
    else $error("unmapped access not refused");

  AST_RDATA_RSV_ZERO: assert property (
    prdata_reg[31:28] == 4'h0 && prdata_reg[15:8] == 8'h00 &&
    prdata_reg[7] == 1'b0 && prdata_reg[3:2] == 2'b00)
    else $error("reserved read data bits not zero");

  for (genvar ch = 0; ch < 4; ch++) begin : g_ast
    AST_CTRL_RSV_ZERO: assert property (
      (ctrl_reg[ch] & ~`QDRC_CTRL_WMASK) == 8'h00)
      else $error("reserved control bits not zero");

    AST_CLEAR_FORCES_ZERO: assert property (
      !ctrl_reg[ch][`QDRC_CLEAR_N_BIT] |=> code_reg[ch] == 12'h000)
      else $error("code not cleared while clear bit low");

    AST_CODE_WRITE: assert property (
      commit && pwrite && paddr[2] && sel_idx == ch && !warm_clear &&
      ctrl_reg[ch][`QDRC_CLEAR_N_BIT]
        |=> code_reg[ch] == $past(pwdata[`QDRC_CODE_MSB:`QDRC_CODE_LSB]))
      else $error("code write did not land");

    AST_CTRL_WRITE: assert property (
      commit && pwrite && !paddr[2] && sel_idx == ch && !warm_clear
        |=> ctrl_reg[ch] == ($past(pwdata[7:0]) & `QDRC_CTRL_WMASK))
      else $error("control write did not land masked");

    AST_CORE_UPDATE: assert property (
      !ctrl_reg[ch][`QDRC_UPDSEL_BIT] && !warm_clear
        |=> dac_in_reg[ch] == $past(code_reg[ch]))
      else $error("core clock update missed");

    AST_TIMER_HOLD: assert property (
      ctrl_reg[ch][`QDRC_UPDSEL_BIT] && !general_timer_one_event &&
      !warm_clear |=> $stable(dac_in_reg[ch]))
      else $error("converter input moved without timer event");

    AST_TIMER_LOAD: assert property (
      ctrl_reg[ch][`QDRC_UPDSEL_BIT] && general_timer_one_event &&
      !warm_clear |=> dac_in_reg[ch] == $past(code_reg[ch]))
      else $error("timer event did not load pending code");

    AST_POWER_DOWN: assert property (
      ctrl_reg[ch][1:0] == 2'b00 && !warm_clear |=> !channel_powered[ch])
      else $error("channel powered with range code 00");

    AST_SUPPLY_REF: assert property (
      ctrl_reg[ch][1:0] == 2'b11 && !warm_clear
        |=> dac_ref_supply[ch] && channel_powered[ch])
      else $error("range 11 not on supply reference");

    AST_INTERNAL_REF: assert property (
      reference_enable && ctrl_reg[ch][1:0] == 2'b10 && !warm_clear
        |=> dac_ref_internal[ch] && adc_ref_external == $past(any_ext_req))
      else $error("range 10 not on internal reference");

    AST_RESERVED_DOWN: assert property (
      !reference_enable && !warm_clear &&
      (ctrl_reg[ch][1:0] == 2'b01 || ctrl_reg[ch][1:0] == 2'b10)
        |=> !channel_powered[ch] && !dac_ref_internal[ch] &&
            !dac_ref_external[ch])
      else $error("reserved range combination not powered down");

    AST_EXTERNAL_REF: assert property (
      reference_enable && ctrl_reg[ch][1:0] == 2'b01 && !warm_clear
        |=> dac_ref_external[ch] && adc_ref_external)
      else $error("range 01 not on external reference");

    AST_BYPASS: assert property (
      !warm_clear |=> buffer_bypass[ch] == $past(ctrl_reg[ch][6]))
      else $error("bypass output does not follow control");

    AST_WARM_DEFAULT: assert property (
      warm_clear |=> ctrl_reg[ch] == 8'h00 && code_reg[ch] == 12'h000
                     && dac_in_reg[ch] == 12'h000
                     && !channel_powered[ch])
      else $error("warm reset did not restore defaults");

    AST_WARM_RETAIN: assert property (
      warm_reset && retention_keep && !psel |=> $stable(ctrl_reg[ch]))
      else $error("retained channel changed on warm reset");
  end

endmodule : qdrc_top

// >>> qdrc_defs.svh
// Offsets, field positions, reset values of the quad converter control.
// Assumes inclusion by bare name from the design and bench files.
`ifndef QDRC_DEFS_SVH
`define QDRC_DEFS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses, one word each)
// ----------------------------------------------------------------------
`define QDRC_CONV0_CONTROL 32'hffff0600
`define QDRC_CONV0_CODE    32'hffff0604
`define QDRC_CONV1_CONTROL 32'hffff0608
`define QDRC_CONV1_CODE    32'hffff060c
`define QDRC_CONV2_CONTROL 32'hffff0610
`define QDRC_CONV2_CODE    32'hffff0614
`define QDRC_CONV3_CONTROL 32'hffff0618
`define QDRC_CONV3_CODE    32'hffff061c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define QDRC_BYPASS_BIT    6
`define QDRC_UPDSEL_BIT    5
`define QDRC_CLEAR_N_BIT   4
`define QDRC_RANGE_MSB     1
`define QDRC_RANGE_LSB     0
`define QDRC_CODE_MSB      27
`define QDRC_CODE_LSB      16
`define QDRC_CTRL_WMASK    8'h73
`define QDRC_CTRL_RESET    8'h00
`define QDRC_CODE_RESET    12'h000

`endif

// >>> qdrc_pkg.sv
// Types shared by the quad converter control block.
// Assumes the offsets and fields come from qdrc_defs.svh.
package qdrc_pkg;

  // Range and power code of a channel control register
  typedef enum logic [1:0] {
    QDRC_RNG_OFF,
    QDRC_RNG_RSV,
    QDRC_RNG_VREF,
    QDRC_RNG_SUPPLY
  } qdrc_range_t;

endpackage : qdrc_pkg

// >>> qdrc_top_test.sv
// Self-checking bench for the quad converter register control block.
// Assumes qdrc_top as an APB slave and qdrc_defs.svh on the include path.
`timescale 1ns/10ps
`include "qdrc_defs.svh"
module qdrc_top_test;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  localparam logic [31:0] BASE = `QDRC_CONV0_CONTROL;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] paddr = 32'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        general_timer_one_event = 1'b0;
  logic        reference_enable = 1'b0;
  logic        warm_reset = 1'b0;
  logic        retention_keep = 1'b0;
  logic [47:0] channel_code_out;
  logic [3:0]  channel_powered;
  logic [3:0]  buffer_bypass;
  logic [3:0]  dac_ref_supply;
  logic [3:0]  dac_ref_internal;
  logic [3:0]  dac_ref_external;
  logic        adc_ref_external;
  int          errors = 0;
  int          cmp_count = 0;
  logic [31:0] rd;
  logic        er;
  logic [4:0]  ex;
  logic [1:0]  rg;
  // Offset, write value, expected read back
  logic [31:0] rows [8][3] = '{
    '{32'h00, 32'hff, 32'h73}, '{32'h04, 32'hffffffff, 32'h0fff0000},
    '{32'h08, 32'h52, 32'h52}, '{32'h0c, 32'ha5a5a5a5, 32'h05a50000},
    '{32'h10, 32'h03, 32'h03}, '{32'h14, 32'h12345678, 32'h0},
    '{32'h18, 32'h1c, 32'h10}, '{32'h1c, 32'h0abc0000, 32'h0abc0000}};

  // 100 MHz core clock
  always #5 sys_clk = ~sys_clk;

  qdrc_top dut_u (.sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pready, .prdata, .pslverr, .general_timer_one_event,
    .reference_enable, .warm_reset, .retention_keep, .channel_code_out,
    .channel_powered, .buffer_bypass, .dac_ref_supply, .dac_ref_internal,
    .dac_ref_external, .adc_ref_external);

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No local limit: only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  // Watchdog: whole run is a few hundred cycles
  initial begin
    tick(5000);
    errors++;
    print_verdict();
  end

  initial begin
    tick(20);
    sys_rst <= 1'b0;
    reference_enable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(BASE + 32'(4 * i), 1'b0, 32'h0, rd, er);
      chk(rd, 32'h0);
    end
    // Table rows: write then read back each register
    for (int i = 0; i < 8; i++) begin
      apb(BASE + rows[i][0], 1'b1, rows[i][1], rd, er);
      apb(BASE + rows[i][0], 1'b0, 32'h0, rd, er);
      chk(rd, rows[i][2]);
      chk({31'h0, er}, 32'h0);
    end
    tick(2);
    chk({20'h0, channel_code_out[23:12]}, 32'h5a5);
    chk({28'h0, buffer_bypass}, 32'h3);
    chk({20'h0, channel_code_out[35:24]}, 32'h0);
    chk({20'h0, channel_code_out[47:36]}, 32'habc);
    chk({20'h0, channel_code_out[11:0]}, 32'h0);
    general_timer_one_event <= 1'b1;
    tick(1);
    general_timer_one_event <= 1'b0;
    tick(2);
    chk({20'h0, channel_code_out[11:0]}, 32'hfff);
    // Every range code against both reference enable levels
    for (int i = 0; i < 8; i++) begin
      rg = i[1:0];
      ex = {rg == 2'd3 || (i[2] && rg != 2'd0), rg == 2'd3,
            i[2] && rg == 2'd2, i[2] && rg == 2'd1, !i[2] || rg == 2'd1};
      reference_enable <= i[2];
      apb(BASE + 32'h18, 1'b1, 32'h10 + 32'(rg), rd, er);
      tick(2);
      chk({27'h0, channel_powered[3], dac_ref_supply[3],
           dac_ref_internal[3], dac_ref_external[3], adc_ref_external},
          {27'h0, ex});
    end
    // Unmapped and misaligned accesses are refused
    apb(BASE + 32'h20, 1'b0, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(BASE + 32'h2, 1'b1, 32'h0, rd, er);
    apb(BASE, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h73);
    // Warm reset with retention, then without
    retention_keep <= 1'b1;
    warm_reset <= 1'b1;
    tick(1);
    warm_reset <= 1'b0;
    tick(2);
    chk({20'h0, channel_code_out[23:12]}, 32'h5a5);
    apb(BASE + 32'hc, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h05a50000);
    retention_keep <= 1'b0;
    warm_reset <= 1'b1;
    tick(1);
    warm_reset <= 1'b0;
    tick(2);
    chk(channel_code_out[31:0], 32'h0);
    chk({28'h0, channel_powered}, 32'h0);
    apb(BASE + 32'h8, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0);
    // Core reset in mid-run clears a channel three supply range written after the warm reset
    apb(BASE + 32'h18, 1'b1, 32'h13, rd, er);
    tick(2);
    chk({28'h0, dac_ref_supply}, 32'h8);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    chk({28'h0, dac_ref_supply}, 32'h0);
    apb(BASE + 32'h18, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule : qdrc_top_test
